// file: hdl/pol_ctrl_cfg.svh
// Constants for the regulator sequencing controller.
// Assumes a 25 MHz system clock; included by bare name.
`ifndef POL_CTRL_CFG_SVH
`define POL_CTRL_CFG_SVH
`define CLK_HZ            25000000
`define CLK_NS            40
`define HICCUP_US         20
`define HICCUP_CYC        ((`HICCUP_US * 1000) / `CLK_NS)
`define INIT_STEP_CYC     16
`define SYNC_LOSS_CYC     64
`define OCP_RESET_RESP    2'h2
`define STRAP_OVR_BIT     0
`define DELAY_STEP_SH     4
`define PHASE_STEPS       128
`define FALL_PCT          10
`define PG_ON_PM          900
`define PG_OFF_PM         850
`define VMAX_PM           1100
`define MHIGH_PM          1050
`define MLOW_PM           950
`define OVF_PM            1150
`define UVF_PM            850
`define PM_DIV            1000
`endif

// file: hdl/pol_ctrl_pkg.sv
// Types used by the regulator end of the control link and by the bench; the host end passes codes as raw bits.
// No dependencies.
package pol_ctrl_pkg;
    typedef enum logic [1:0] {OCP_CONTINUE = 2'h0, OCP_LATCH = 2'h1, OCP_HICCUP = 2'h2} ocp_resp_t;
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0, CMD_OCP_RESP = 4'h1, CMD_FREQ = 4'h2, CMD_INTERLEAVE = 4'h3,
        CMD_TON_DELAY = 4'h4, CMD_TON_RISE = 4'h5, CMD_TOFF_DELAY = 4'h6,
        CMD_TOFF_FALL = 4'h7, CMD_ON_OFF_CFG = 4'h8, CMD_CLEAR_FAULT = 4'h9,
        CMD_VOUT = 4'hA, CMD_TON_MAX_RESP = 4'hB
    } cmd_t;
endpackage : pol_ctrl_pkg

// file: hdl/pol_link_if.sv
// Command link between the management host and the regulator controller.
// Also carries the external sync clock; the bench drives clk and reset.
interface pol_link_if;
    logic        cmd_valid;
    logic [3:0]  cmd_code;
    logic [15:0] cmd_data;
    logic        cmd_ready;
    logic [15:0] rd_data;
    logic        init_done;
    logic        sync_clk;
    modport device (input cmd_valid, input cmd_code, input cmd_data, input sync_clk,
                    output cmd_ready, output rd_data, output init_done);
    modport host   (output cmd_valid, output cmd_code, output cmd_data, output sync_clk,
                    input cmd_ready, input rd_data, input init_done);
endinterface : pol_link_if

// file: hdl/step_timer.sv
// Loadable down-counter shared by delay, ramp and hiccup timing.
// Same clock domain as its user.
module step_timer #(
    parameter int W = 16
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    output logic              busy,
    output logic              done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         busy;
        logic         done;
    } st_t;
    st_t st_reg;
    st_t st_next;
    if (W < 2)
    begin : g_bad_width
        $error("step_timer width too small");
    end
    always_comb
    begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (load)
        begin
            st_next.cnt  = count;
            st_next.busy = 1'b1;
        end
        else if (st_reg.busy)
        begin
            if (st_reg.cnt == '0)
            begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end
            else
                st_next.cnt = st_reg.cnt - W'(1);
        end
    end
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            st_reg <= '0;
        else if (clk_en)
            st_reg <= st_next;
    end
    assign busy = st_reg.busy;
    assign done = st_reg.done;
endmodule : step_timer

// file: hdl/pol_device.sv
// Regulator digital control: OCP, sync detect, phase, init and soft start/stop.
// Assumes sync_clk from the link is asynchronous; rst_n models supply application.
`include "pol_ctrl_cfg.svh"
module pol_device #(
    parameter int          HICCUP_CYC = `HICCUP_CYC,
    parameter logic [15:0] VOUT_DEF   = 16'h0000
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    pol_link_if.device       link,
    input  wire logic [2:0]  addr_strap,
    input  wire logic [15:0] vout_strap,
    input  wire logic [15:0] vout_stored,
    input  wire logic [15:0] strap_override,
    input  wire logic        selftest_ok,
    input  wire logic        out_enable,
    input  wire logic        overcurrent,
    input  wire logic [15:0] vout_sense,
    output logic             output_on,
    output logic             ramp_up,
    output logic             ramp_down,
    output logic             fault_latched,
    output logic             ext_sync_used,
    output logic [6:0]       phase_steps,
    output logic [15:0]      vout_level,
    output logic [15:0]      pg_on_level,
    output logic [15:0]      pg_off_level,
    output logic [15:0]      vout_max_level,
    output logic [15:0]      margin_high_level,
    output logic [15:0]      margin_low_level,
    output logic [15:0]      ov_fault_level,
    output logic [15:0]      uv_fault_level
);
    if (HICCUP_CYC < 1 || HICCUP_CYC > 65535)
    begin : g_bad_hiccup
        $error("HICCUP_CYC out of range");
    end
    typedef enum logic [9:0] {
        S_SELFTEST = 10'h001, S_ADDR = 10'h002, S_STRAP = 10'h004, S_STORE = 10'h008,
        S_SYNC = 10'h010, S_OFF = 10'h020, S_ON_DLY = 10'h040, S_RISE = 10'h080,
        S_ON = 10'h100, S_OFF_SEQ = 10'h200
    } st_e_t;
    typedef struct packed {
        st_e_t                state;
        logic [2:0]           sy;      // Two-flop sync chain plus edge history
        logic                 en_d;
        logic [7:0]           loss_cnt;
        logic                 sync_ok;
        logic                 fall_ph; // Fall phase within off sequence
        logic                 hiccup;
        logic                 latched;
        logic [2:0]           addr;
        logic [15:0]          vout;
        pol_ctrl_pkg::ocp_resp_t ocp;
        logic [15:0]          ilv;
        logic [15:0]          ton_dly, ton_rise, toff_dly, toff_fall;
        logic                 soft_stop;
        logic [15:0]          rd;
        logic                 init_done;
        logic [15:0]          init_cnt;
    } st_t;
    st_t s_reg;
    st_t s_next;
    logic        t_load;
    logic [15:0] t_cnt;
    logic        t_busy;
    logic        t_done;
    logic        sync_rise;
    logic [3:0]  grp;
    logic [10:0] ph_prod;
    logic [6:0]  ilv_ph;
    step_timer #(.W(16)) u_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .load    (t_load),
        .count   (t_cnt),
        .busy    (t_busy),
        .done    (t_done)
    );
    assign sync_rise = s_reg.sy[1] & ~s_reg.sy[2];
    // Rounds to nearest multiple of the delay-generator step
    function automatic logic [15:0] quant(input logic [15:0] v);
        logic [16:0] r;
        r = {1'b0, v} + 17'h00008;
        quant = {r[15:4], 4'h0};
    endfunction : quant
    function automatic logic [15:0] scale(input logic [15:0] v, input int pm);
        logic [31:0] p;
        p = (32'(v) * 32'(pm)) / 32'(`PM_DIV);
        scale = p[15:0];
    endfunction : scale
    always_comb
    begin
        grp     = s_reg.ilv[3:0];
        ph_prod = 11'(s_reg.ilv[7:4]) * 11'(`PHASE_STEPS);
        // Rounds to the nearest step, like the address table
        ilv_ph  = (grp == 4'h0) ? ph_prod[10:4]
                                : 7'((ph_prod + 11'(grp >> 1)) / 11'(grp));
        case (s_reg.addr)
            3'h0: phase_steps = 7'h00;
            3'h1: phase_steps = 7'h15;
            3'h2: phase_steps = 7'h2B;
            3'h3: phase_steps = 7'h40;
            3'h4: phase_steps = 7'h55;
            3'h5: phase_steps = 7'h6B;
            3'h6: phase_steps = 7'h20;
            default: phase_steps = 7'h60;
        endcase
        if (s_reg.ilv != 16'h0000)
            phase_steps = ilv_ph;
    end
    always_comb
    begin
        s_next         = s_reg;
        t_load         = 1'b0;
        t_cnt          = 16'h0000;
        s_next.sy      = {s_reg.sy[1:0], link.sync_clk};
        s_next.en_d    = out_enable;
        // Sync presence: edges keep count reset; silence drops to internal osc
        if (sync_rise)
        begin
            s_next.loss_cnt = 8'h00;
            s_next.sync_ok  = 1'b1;
        end
        else if (s_reg.loss_cnt == 8'(`SYNC_LOSS_CYC))
            s_next.sync_ok = 1'b0;
        else
            s_next.loss_cnt = s_reg.loss_cnt + 8'h01;
        if (link.cmd_valid && s_reg.init_done)
        begin
            case (link.cmd_code)
                pol_ctrl_pkg::CMD_OCP_RESP:
                    if (link.cmd_data[1:0] <= 2'h2)
                        s_next.ocp = pol_ctrl_pkg::ocp_resp_t'(link.cmd_data[1:0]);
                pol_ctrl_pkg::CMD_INTERLEAVE: s_next.ilv = link.cmd_data;
                pol_ctrl_pkg::CMD_TON_DELAY:  s_next.ton_dly = quant(link.cmd_data);
                pol_ctrl_pkg::CMD_TON_RISE:   s_next.ton_rise = quant(link.cmd_data);
                pol_ctrl_pkg::CMD_TOFF_DELAY: s_next.toff_dly = quant(link.cmd_data);
                pol_ctrl_pkg::CMD_TOFF_FALL:  s_next.toff_fall = quant(link.cmd_data);
                pol_ctrl_pkg::CMD_ON_OFF_CFG: s_next.soft_stop = link.cmd_data[0];
                pol_ctrl_pkg::CMD_CLEAR_FAULT: s_next.latched = 1'b0;
                default: ;
            endcase
            case (link.cmd_code)
                pol_ctrl_pkg::CMD_OCP_RESP:   s_next.rd = {14'h0000, s_next.ocp};
                pol_ctrl_pkg::CMD_INTERLEAVE: s_next.rd = s_next.ilv;
                pol_ctrl_pkg::CMD_TON_DELAY:  s_next.rd = s_next.ton_dly;
                pol_ctrl_pkg::CMD_TON_RISE:   s_next.rd = s_next.ton_rise;
                pol_ctrl_pkg::CMD_TOFF_DELAY: s_next.rd = s_next.toff_dly;
                pol_ctrl_pkg::CMD_TOFF_FALL:  s_next.rd = s_next.toff_fall;
                default:                      s_next.rd = s_reg.vout;
            endcase
        end
        case (s_reg.state)
            S_SELFTEST:
                if (selftest_ok)
                    s_next.state = S_ADDR;
            S_ADDR:
            begin
                s_next.addr  = addr_strap;
                s_next.state = S_STRAP;
            end
            S_STRAP:
            begin
                s_next.vout  = strap_override[`STRAP_OVR_BIT] ? vout_stored : vout_strap;
                s_next.state = S_STORE;
            end
            S_STORE:
                s_next.state = S_SYNC;
            S_SYNC:
            begin
                s_next.init_cnt = s_reg.init_cnt + 16'h0001;
                if (s_reg.init_cnt == 16'(`INIT_STEP_CYC))
                begin
                    s_next.init_done = 1'b1;
                    s_next.state     = S_OFF;
                end
            end
            S_OFF:
                // A fresh enable edge restarts after latch-off too; the latch clears below
                if (out_enable && !s_reg.en_d)
                begin
                    s_next.hiccup   = 1'b0;
                    s_next.loss_cnt = 8'h00;
                    t_load       = 1'b1;
                    t_cnt        = s_reg.ton_dly;
                    s_next.state = S_ON_DLY;
                end
                else if (s_reg.hiccup && t_done && out_enable)
                begin
                    s_next.hiccup = 1'b0;
                    t_load       = 1'b1;
                    t_cnt        = s_reg.ton_rise;
                    s_next.state = S_RISE;
                end
            S_ON_DLY:
                if (!out_enable)
                    s_next.state = S_OFF;
                else if (t_done)
                begin
                    t_load       = 1'b1;
                    t_cnt        = s_reg.ton_rise;
                    s_next.state = S_RISE;
                end
            S_RISE:
                if (!out_enable)
                    s_next.state = S_OFF;
                else if (t_done && vout_sense >= s_reg.vout)
                    s_next.state = S_ON;
            S_ON:
                if (overcurrent && s_reg.ocp != pol_ctrl_pkg::OCP_CONTINUE)
                begin
                    s_next.state = S_OFF;
                    if (s_reg.ocp == pol_ctrl_pkg::OCP_LATCH)
                        s_next.latched = 1'b1;
                    else
                    begin
                        s_next.hiccup = 1'b1;
                        t_load        = 1'b1;
                        t_cnt         = 16'(HICCUP_CYC);
                    end
                end
                else if (!out_enable)
                begin
                    s_next.fall_ph = 1'b0;
                    if (s_reg.soft_stop)
                    begin
                        t_load       = 1'b1;
                        t_cnt        = s_reg.toff_dly;
                        s_next.state = S_OFF_SEQ;
                    end
                    else
                        s_next.state = S_OFF;
                end
            S_OFF_SEQ:
                if (!s_reg.fall_ph && t_done)
                begin
                    s_next.fall_ph = 1'b1;
                    t_load         = 1'b1;
                    t_cnt          = s_reg.toff_fall;
                end
                else if (s_reg.fall_ph && !t_busy && !t_load &&
                         32'(vout_sense) * 32'(100) < 32'(s_reg.vout) * 32'(`FALL_PCT))
                    s_next.state = S_OFF;
            default: s_next.state = S_SELFTEST;
        endcase
        // Re-enable clears a latched fault
        if (out_enable && !s_reg.en_d && s_reg.state == S_OFF)
            s_next.latched = 1'b0;
    end
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            s_reg           <= '0;
            s_reg.state     <= S_SELFTEST;
            s_reg.ocp       <= pol_ctrl_pkg::ocp_resp_t'(`OCP_RESET_RESP);
            s_reg.soft_stop <= 1'b0;
            s_reg.vout      <= VOUT_DEF;
        end
        else if (clk_en)
            s_reg <= s_next;
    end
    // Defaults derive only from the level latched at init, so a later store waits a power cycle
    assign pg_on_level       = scale(s_reg.vout, `PG_ON_PM);
    assign pg_off_level      = scale(s_reg.vout, `PG_OFF_PM);
    assign vout_max_level    = scale(s_reg.vout, `VMAX_PM);
    assign margin_high_level = scale(s_reg.vout, `MHIGH_PM);
    assign margin_low_level  = scale(s_reg.vout, `MLOW_PM);
    assign ov_fault_level    = scale(s_reg.vout, `OVF_PM);
    assign uv_fault_level    = scale(s_reg.vout, `UVF_PM);
    assign vout_level        = s_reg.vout;
    assign output_on         = (s_reg.state == S_ON) || (s_reg.state == S_RISE) ||
                               (s_reg.state == S_OFF_SEQ);
    assign ramp_up           = s_reg.state == S_RISE;
    assign ramp_down         = (s_reg.state == S_OFF_SEQ) && s_reg.fall_ph;
    assign fault_latched     = s_reg.latched;
    assign ext_sync_used     = s_reg.sync_ok;
    assign link.cmd_ready    = s_reg.init_done;
    assign link.rd_data      = s_reg.rd;
    assign link.init_done    = s_reg.init_done;
endmodule : pol_device

// file: hdl/pol_host.sv
// Host end: issues commands after init and makes the sync clock by division.
// Assumes the user side holds req until the command is taken.
`include "pol_ctrl_cfg.svh"
module pol_host #(
    parameter int DIV = 4
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    pol_link_if.host         link,
    input  wire logic        sync_run,
    input  wire logic        req,
    input  wire logic [3:0]  req_code,
    input  wire logic [15:0] req_data,
    output logic             req_ack,
    output logic [15:0]      resp_data
);
    if (DIV < 1 || DIV > 255)
    begin : g_bad_div
        $error("DIV out of range");
    end
    typedef struct packed {
        logic [7:0]  div_cnt;
        logic        sck;
        logic [15:0] resp;
        logic        ack;
    } st_t;
    st_t s_reg;
    st_t s_next;
    logic take;
    assign take = req && link.cmd_ready && link.init_done;
    always_comb
    begin
        s_next     = s_reg;
        s_next.ack = take;
        if (s_reg.div_cnt == 8'(DIV - 1))
        begin
            s_next.div_cnt = 8'h00;
            s_next.sck     = sync_run & ~s_reg.sck;
        end
        else
            s_next.div_cnt = s_reg.div_cnt + 8'h01;
        if (s_reg.ack)
            s_next.resp = link.rd_data;
    end
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            s_reg <= '0;
        else if (clk_en)
            s_reg <= s_next;
    end
    // are host software duties; commands pass through unchanged
    assign link.cmd_valid = take;
    assign link.cmd_code  = req_code;
    assign link.cmd_data  = req_data;
    assign link.sync_clk  = s_reg.sck;
    assign req_ack        = s_reg.ack;
    assign resp_data      = s_reg.resp;
endmodule : pol_host

// file: bench/regulator_fault_sync_sequencing_sva.sv
// Assertions on the host/regulator command link.
// Fed the link signals directly by the bench; one clock domain.
module regulator_fault_sync_sequencing_sva (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        cmd_valid,
    input wire logic [3:0]  cmd_code,
    input wire logic [15:0] cmd_data,
    input wire logic        cmd_ready,
    input wire logic [15:0] rd_data,
    input wire logic        init_done,
    input wire logic        sync_clk
);
    logic [7:0] age_reg;
    logic [7:0] age_next;
    // Saturates so a long run never wraps
    always_comb age_next = (age_reg == 8'hFF) ? age_reg : age_reg + 8'h01;
    always_ff @(posedge sys_clk) age_reg <= rst_n ? age_next : 8'h00;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_cmd_gate; cmd_valid |-> init_done; endproperty
    a_cmd_gate: assert property (p_cmd_gate) else $error("command before init");
    property p_ready; cmd_ready == init_done; endproperty
    a_ready: assert property (p_ready) else $error("ready differs from init");
    property p_init_keep; init_done |=> init_done; endproperty
    a_init_keep: assert property (p_init_keep) else $error("init dropped");
    property p_init_time; init_done |-> age_reg >= 8'h11; endproperty
    a_init_time: assert property (p_init_time) else $error("init too short");
    property p_round; cmd_valid && cmd_code inside {[4'h4:4'h7]} && cmd_data[3:0] != 4'h8
        && cmd_data < 16'hFFF0 |=> rd_data == (($past(cmd_data) + 16'h0008) & 16'hFFF0); endproperty
    a_round: assert property (p_round) else $error("time not rounded to nearest");
    property p_grid; $past(cmd_valid) && $past(cmd_code) == 4'h7 |-> rd_data[3:0] == 4'h0; endproperty
    a_grid: assert property (p_grid) else $error("fall time off grid");
    property p_rd_hold; !cmd_valid |=> $stable(rd_data); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("readback moved");
    property p_sync_hold; $changed(sync_clk) |=> $stable(sync_clk); endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("sync clock too fast");
endmodule : regulator_fault_sync_sequencing_sva

// file: bench/regulator_fault_sync_sequencing_tb.sv
// Bench for host and regulator ends joined over the command link.
// Assumes package, interface and design modules compiled first.
module regulator_fault_sync_sequencing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HICCUP = 8;
    logic        sys_clk = 1'b0;
    logic        clk_en = 1'b1;
    logic        rst_n = 1'b0;
    logic        sync_run = 1'b0;
    logic        req = 1'b0;
    logic [3:0]  req_code = 4'h0;
    logic [15:0] req_data = 16'h0000;
    logic [2:0]  addr_strap = 3'h0;
    logic [15:0] vout_strap = 16'h0000;
    logic [15:0] vout_stored = 16'h0000;
    logic [15:0] strap_override = 16'h0000;
    logic        selftest_ok = 1'b0;
    logic        out_enable = 1'b0;
    logic        overcurrent = 1'b0;
    logic [15:0] vout_sense = 16'h0000;
    logic        req_ack;
    logic [15:0] resp_data;
    logic        output_on;
    logic        ramp_up;
    logic        ramp_down;
    logic        fault_latched;
    logic        ext_sync_used;
    logic [6:0]  phase_steps;
    logic [15:0] lv [8];
    int          failures = 0;
    int          checks_done = 0;
    int          n;
    int          d;
    int          v;
    int          exp_q [$];
    int          deg [8] = '{0, 60, 120, 180, 240, 300, 90, 270};
    int          pm [8] = '{1000, 900, 850, 1100, 1050, 950, 1150, 850};
    int          ord [4] = '{1, 3, 1, 5};
    int          grp [4] = '{0, 4, 3, 8};
    pol_link_if pol_link_if_inst ();
    pol_device #(.HICCUP_CYC(HICCUP)) pol_device_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .clk_en(clk_en), .link(pol_link_if_inst), .addr_strap(addr_strap), .vout_strap(vout_strap),
        .vout_stored(vout_stored), .strap_override(strap_override), .selftest_ok(selftest_ok),
        .out_enable(out_enable), .overcurrent(overcurrent), .vout_sense(vout_sense),
        .output_on(output_on), .ramp_up(ramp_up), .ramp_down(ramp_down),
        .fault_latched(fault_latched), .ext_sync_used(ext_sync_used), .phase_steps(phase_steps),
        .vout_level(lv[0]), .pg_on_level(lv[1]), .pg_off_level(lv[2]), .vout_max_level(lv[3]),
        .margin_high_level(lv[4]), .margin_low_level(lv[5]), .ov_fault_level(lv[6]),
        .uv_fault_level(lv[7]));
    pol_host pol_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .link(pol_link_if_inst), .sync_run(sync_run), .req(req), .req_code(req_code),
        .req_data(req_data), .req_ack(req_ack), .resp_data(resp_data));
    regulator_fault_sync_sequencing_sva regulator_fault_sync_sequencing_sva_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(pol_link_if_inst.cmd_valid),
        .cmd_code(pol_link_if_inst.cmd_code), .cmd_data(pol_link_if_inst.cmd_data),
        .cmd_ready(pol_link_if_inst.cmd_ready), .rd_data(pol_link_if_inst.rd_data),
        .init_done(pol_link_if_inst.init_done), .sync_clk(pol_link_if_inst.sync_clk));
    always #20 sys_clk = ~sys_clk;
    // Load follows the target except while ramping down
    always @(negedge sys_clk) vout_sense <= ramp_down ? 16'h0000 : lv[0];
    task automatic stop_test();
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic probe(input int i);
        case (i)
            0: return ramp_up;
            1: return output_on;
            2: return ramp_down;
            3: return ext_sync_used;
            default: return pol_link_if_inst.init_done;
        endcase
    endfunction : probe
    task automatic wt(input int i, input logic lvl, input int lim);
        for (n = 0; n < lim && probe(i) !== lvl; n++)
            @(negedge sys_clk);
        if (probe(i) !== lvl)
        begin
            chk(16'(probe(i)), 16'(lvl));
            stop_test();
        end
    endtask : wt
    // Ready is a register: seen high here, the next edge takes; exp below zero skips readback
    task automatic cmd(input logic [3:0] code, input logic [15:0] data, input int exp);
        wt(4, 1'b1, 2000);
        req = 1'b1;
        req_code = code;
        req_data = data;
        exp_q.push_back(exp);
        @(negedge sys_clk);
        req = 1'b0;
        chk(16'(req_ack), 16'h0001);
        @(negedge sys_clk);
        v = exp_q.pop_front();
        if (v >= 0)
            chk(resp_data, 16'(v));
    endtask : cmd
    task automatic trip(input int on, input int lat);
        overcurrent = 1'b1;
        @(negedge sys_clk);
        overcurrent = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk(16'(output_on), 16'(on));
        chk(16'(fault_latched), 16'(lat));
    endtask : trip
    task automatic power_up();
        out_enable = 1'b0;
        @(negedge sys_clk);
        out_enable = 1'b1;
        wt(0, 1'b1, 60);
        wt(0, 1'b0, 60);
    endtask : power_up
    initial
    begin
        void'($urandom(32'hA1A7));
        for (int a = 0; a < 8; a++)
        begin
            addr_strap = 3'(a);
            vout_strap = 16'($urandom_range(32767, 256));
            vout_stored = 16'($urandom_range(32767, 256));
            strap_override = 16'($urandom);
            v = strap_override[0] ? int'(vout_stored) : int'(vout_strap);
            // Even passes freeze the clock with selftest passed; odd ones run with it failing
            clk_en = 1'(a % 2);
            selftest_ok = ~clk_en;
            rst_n = 1'b0;
            repeat (3) @(negedge sys_clk);
            rst_n = 1'b1;
            repeat (30) @(negedge sys_clk);
            chk(16'(pol_link_if_inst.init_done), 16'h0000);
            clk_en = 1'b1;
            selftest_ok = 1'b1;
            wt(4, 1'b1, 40);
            d = $urandom_range(4080, 0);
            d = (d % 16 == 8) ? d + 1 : d;
            vout_strap = ~vout_strap;
            vout_stored = ~vout_stored;
            repeat (2) @(negedge sys_clk);
            for (int k = 0; k < 8; k++)
                chk(lv[k], 16'(v * pm[k] / 1000));
            cmd(4'(a % 4 + 4), 16'(d), (d + 8) / 16 * 16);
            chk(16'(phase_steps), 16'((deg[a] * 128 + 180) / 360));
            $display("init pass %0d done", a);
        end
        for (int i = 0; i < 4; i++)
        begin
            d = (grp[i] == 0) ? 16 : grp[i];
            cmd(pol_ctrl_pkg::CMD_INTERLEAVE, {8'h00, 4'(ord[i]), 4'(grp[i])}, -1);
            repeat (2) @(negedge sys_clk);
            chk(16'(phase_steps), 16'((ord[i] * 256 + d) / (2 * d)));
        end
        cmd(pol_ctrl_pkg::CMD_INTERLEAVE, 16'h0000, -1);
        repeat (2) @(negedge sys_clk);
        chk(16'(phase_steps), 16'h0060);
        $display("phase test done");
        cmd(pol_ctrl_pkg::CMD_TON_DELAY, 16'h0010, 16);
        cmd(pol_ctrl_pkg::CMD_TON_RISE, 16'h0011, 16);
        // Switching frequency stays at default, so no compensation retune is owed
        sync_run = 1'b1;
        repeat (20) @(negedge sys_clk);
        out_enable = 1'b1;
        wt(0, 1'b1, 60);
        chk(16'(n >= 15 && n <= 20), 16'h0001);
        trip(1, 0);
        wt(0, 1'b0, 60);
        chk(16'(output_on & ext_sync_used), 16'h0001);
        trip(0, 0);
        wt(0, 1'b1, 60);
        chk(16'(n >= HICCUP - 1 && n <= HICCUP + 22), 16'h0001);
        wt(0, 1'b0, 60);
        cmd(pol_ctrl_pkg::CMD_OCP_RESP, 16'h0001, -1);
        cmd(pol_ctrl_pkg::CMD_TON_MAX_RESP, 16'h0001, -1);
        trip(0, 1);
        repeat (3 * HICCUP) @(negedge sys_clk);
        chk(16'({fault_latched, output_on, ramp_up}), 16'h0004);
        cmd(pol_ctrl_pkg::CMD_CLEAR_FAULT, 16'h0000, -1);
        chk(16'(fault_latched), 16'h0000);
        power_up();
        cmd(pol_ctrl_pkg::CMD_OCP_RESP, 16'h0003, -1);
        trip(0, 1);
        power_up();
        chk(16'(fault_latched), 16'h0000);
        cmd(pol_ctrl_pkg::CMD_OCP_RESP, 16'h0000, -1);
        trip(1, 0);
        $display("overcurrent test done");
        sync_run = 1'b0;
        wt(3, 1'b0, 150);
        chk(16'(n >= 56 && output_on), 16'h0001);
        out_enable = 1'b0;
        wt(1, 1'b0, 3);
        cmd(pol_ctrl_pkg::CMD_ON_OFF_CFG, 16'h0001, -1);
        cmd(pol_ctrl_pkg::CMD_TOFF_DELAY, 16'h0021, 32);
        cmd(pol_ctrl_pkg::CMD_TOFF_FALL, 16'h0014, 16);
        power_up();
        out_enable = 1'b0;
        repeat (20) @(negedge sys_clk);
        chk(16'(ramp_down), 16'h0000);
        wt(2, 1'b1, 40);
        wt(1, 1'b0, 60);
        $display("soft stop test done");
        stop_test();
    end
    initial
    begin
        #2000000;
        failures++;
        stop_test();
    end
endmodule : regulator_fault_sync_sequencing_tb
